// ===== hw/gpc_pkg.sv
`default_nettype none
package gpc_pkg;
  // Port numbering: A, B, C, E, F, G, L share one layout
  localparam int NPORT = 7;
  localparam int PW    = 8;
  localparam int IDX_F = 4;
  localparam int IDX_G = 5;
  localparam int IDX_L = 6;

  // Register map, byte addresses
  localparam logic [7:0] PORT_BASE [NPORT] = '{
    8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  localparam logic [1:0] OFF_CFG    = 2'h0;
  localparam logic [1:0] OFF_DAT    = 2'h1;
  localparam logic [1:0] OFF_PIN    = 2'h2;
  localparam logic [7:0] OFF_PORT_D = 8'h1C;
  localparam logic [2:0] IDX_NONE   = 3'h7;

  // Reset values
  localparam logic [7:0] RST_CFG    = 8'h00;
  localparam logic [7:0] RST_DAT    = 8'h00;
  localparam logic [7:0] RST_PORT_D = 8'hFF;

  // Implemented bits per port
  localparam logic [7:0] MASK_FULL  = 8'hFF;
  localparam logic [7:0] MASK_F     = 8'h0F;

  // Port G special bit positions
  localparam int G_INT_BIT     = 0;
  localparam int G_WDOG_BIT    = 1;
  localparam int G_CAP_BIT     = 2;
  localparam int G_T1IO_BIT    = 3;
  localparam int G_SCLK_BIT    = 5;
  localparam int G_SIN_BIT     = 6;
  localparam int G_CLKOUT_BIT  = 7;
  localparam int G_IDLE_BIT    = 6;
  localparam int G_HALT_BIT    = 7;
  localparam int G_PHASE_BIT   = 6;
  localparam int G_DELAY_BIT   = 7;
  localparam logic [7:0] G_DAT_RD_MASK = 8'h3F;

  // State of one port cell
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] dat;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } gpc_cell_state_t;

  // State of the top level
  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] port_d;
    logic       halt;
    logic       idle;
    logic       dly_en;
  } gpc_top_state_t;
endpackage
`default_nettype wire

// ===== hw/gpc_port_cell.sv
`default_nettype none
module gpc_port_cell #(
  parameter logic [7:0] IMPL_MASK = gpc_pkg::MASK_FULL
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_wr_cfg,
  input  wire logic       i_wr_dat,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_pin,
  input  wire logic [7:0] i_alt_en,
  input  wire logic [7:0] i_alt_val,
  input  wire logic [7:0] i_ovr_en,
  input  wire logic [7:0] i_ovr_oe,
  input  wire logic [7:0] i_ovr_out,
  input  wire logic [7:0] i_ovr_pull,
  output logic      [7:0] o_cfg,
  output logic      [7:0] o_dat,
  output logic      [7:0] o_level,
  output logic      [7:0] o_out,
  output logic      [7:0] o_oe,
  output logic      [7:0] o_pull
);
  gpc_pkg::gpc_cell_state_t s_reg;
  gpc_pkg::gpc_cell_state_t s_next;

  // Register writes, pin sampling and per-bit drive
  always_comb begin
    s_next = s_reg;
    if (i_wr_cfg) begin
      s_next.cfg = i_wdata & IMPL_MASK;
    end
    if (i_wr_dat) begin
      s_next.dat = i_wdata & IMPL_MASK;
    end
    s_next.sync1 = i_pin & IMPL_MASK;
    s_next.sync2 = s_reg.sync1;
    for (int b = 0; b < 8; b++) begin
      if (i_ovr_en[b]) begin
        s_next.oe[b]   = i_ovr_oe[b];
        s_next.out[b]  = i_ovr_out[b];
        s_next.pull[b] = i_ovr_pull[b];
      end else begin
        s_next.oe[b]   = s_next.cfg[b];
        s_next.out[b]  = i_alt_en[b] ? i_alt_val[b] : s_next.dat[b];
        s_next.pull[b] = ~s_next.cfg[b] & s_next.dat[b];
      end
    end
    s_next.oe   = s_next.oe & IMPL_MASK;
    s_next.out  = s_next.out & IMPL_MASK;
    s_next.pull = s_next.pull & IMPL_MASK;
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_reg <= '{cfg: gpc_pkg::RST_CFG, dat: gpc_pkg::RST_DAT,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_cfg   = s_reg.cfg;
  assign o_dat   = s_reg.dat;
  assign o_level = s_reg.sync2;
  assign o_out   = s_reg.out;
  assign o_oe    = s_reg.oe;
  assign o_pull  = s_reg.pull;
endmodule
`default_nettype wire

// ===== hw/gpc_top.sv
// Our own choices: the placing of the registers and strobed register access.
`default_nettype none
module gpc_top #(
  parameter int NPORT = gpc_pkg::NPORT
) (
  input  wire logic               I_MCLK,
  input  wire logic               I_RST_B,
  input  wire logic [7:0]         I_ADDR,
  input  wire logic [7:0]         I_WDATA,
  input  wire logic               I_WR,
  input  wire logic               I_RD,
  output logic      [7:0]         O_RDATA,
  input  wire logic [NPORT*8-1:0] I_PIO_IN,
  output logic      [NPORT*8-1:0] O_PIO_OUT,
  output logic      [NPORT*8-1:0] O_PIO_OE,
  output logic      [NPORT*8-1:0] O_PIO_PULLUP,
  output logic      [7:0]         O_PORT_D,
  input  wire logic               I_WDOG_SEL,
  input  wire logic               I_WDOG_OUT_B,
  input  wire logic               I_OSC_CLK,
  input  wire logic               I_RC_CLOCK_MODE,
  input  wire logic [7:0]         I_G_ALT_EN,
  input  wire logic [7:0]         I_G_ALT_OUT,
  input  wire logic [7:0]         I_L_ALT_EN,
  input  wire logic [7:0]         I_L_ALT_OUT,
  output logic                    O_HALT_REQ,
  output logic                    O_IDLE_REQ,
  output logic                    O_SERIAL_ALT_PHASE,
  output logic                    O_HALT_EXIT_STARTUP_DELAY_EN,
  output logic                    O_EXTERNAL_INTERRUPT_IN,
  output logic                    O_TIMER1_CAPTURE_IN,
  output logic                    O_TIMER1_IO_IN,
  output logic                    O_SERIAL_DATA_IN,
  output logic                    O_SERIAL_SHIFT_CLOCK_IN,
  output logic      [7:0]         O_WAKEUP_LEVEL
);
  // Only the documented port count fits the fixed register map
  if (NPORT != gpc_pkg::NPORT) begin : g_bad_nport
    $error("gpc_top: NPORT must equal the fixed port count");
  end

  gpc_pkg::gpc_top_state_t s_reg;
  gpc_pkg::gpc_top_state_t s_next;

  logic [7:0] cfg_w   [NPORT];
  logic [7:0] dat_w   [NPORT];
  logic [7:0] level_w [NPORT];
  logic [7:0] out_w   [NPORT];
  logic [7:0] oe_w    [NPORT];
  logic [7:0] pull_w  [NPORT];
  logic [7:0] alt_en_w  [NPORT];
  logic [7:0] alt_val_w [NPORT];
  logic [7:0] ovr_en_w  [NPORT];
  logic [7:0] ovr_oe_w  [NPORT];
  logic [7:0] ovr_out_w [NPORT];
  logic [7:0] ovr_pull_w[NPORT];
  logic [NPORT-1:0] wr_cfg;
  logic [NPORT-1:0] wr_dat;
  logic [2:0]       wr_idx;
  logic [2:0]       rd_idx;

  // Port whose three-register group holds the address
  function automatic logic [2:0] port_index(input logic [7:0] a);
    logic [2:0] r;
    r = gpc_pkg::IDX_NONE;
    for (int p = 0; p < gpc_pkg::NPORT; p++) begin
      if ({a[7:2], 2'b00} == gpc_pkg::PORT_BASE[p] &&
          a[1:0] != 2'h3) begin
        r = 3'(p);
      end
    end
    return r;
  endfunction

  assign wr_idx = port_index(I_ADDR);
  assign rd_idx = wr_idx;

  // Write strobes into the port cells; pin level is read only
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      wr_cfg[p] = I_WR && wr_idx == 3'(p) &&
                  I_ADDR[1:0] == gpc_pkg::OFF_CFG;
      wr_dat[p] = I_WR && wr_idx == 3'(p) &&
                  I_ADDR[1:0] == gpc_pkg::OFF_DAT;
    end
  end

  // Alternate outputs and fixed pin functions per port
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      alt_en_w[p]   = '0;
      alt_val_w[p]  = '0;
      ovr_en_w[p]   = '0;
      ovr_oe_w[p]   = '0;
      ovr_out_w[p]  = '0;
      ovr_pull_w[p] = '0;
    end
    alt_en_w[gpc_pkg::IDX_G]  = I_G_ALT_EN;
    alt_val_w[gpc_pkg::IDX_G] = I_G_ALT_OUT;
    alt_en_w[gpc_pkg::IDX_L]  = I_L_ALT_EN;
    alt_val_w[gpc_pkg::IDX_L] = I_L_ALT_OUT;
    // G6 input only, never driven
    ovr_en_w[gpc_pkg::IDX_G][gpc_pkg::G_SIN_BIT]    = 1'b1;
    ovr_oe_w[gpc_pkg::IDX_G][gpc_pkg::G_SIN_BIT]    = 1'b0;
    // G7 carries the oscillator clock
    ovr_en_w[gpc_pkg::IDX_G][gpc_pkg::G_CLKOUT_BIT]  = 1'b1;
    ovr_oe_w[gpc_pkg::IDX_G][gpc_pkg::G_CLKOUT_BIT]  = 1'b1;
    ovr_out_w[gpc_pkg::IDX_G][gpc_pkg::G_CLKOUT_BIT] = I_OSC_CLK;
    // G1 as watchdog output: pulls high, sinks while active
    if (I_WDOG_SEL) begin
      ovr_en_w[gpc_pkg::IDX_G][gpc_pkg::G_WDOG_BIT]   = 1'b1;
      ovr_oe_w[gpc_pkg::IDX_G][gpc_pkg::G_WDOG_BIT]   = ~I_WDOG_OUT_B;
      ovr_out_w[gpc_pkg::IDX_G][gpc_pkg::G_WDOG_BIT]  = 1'b0;
      ovr_pull_w[gpc_pkg::IDX_G][gpc_pkg::G_WDOG_BIT] = 1'b1;
    end
  end

  // One cell per bidirectional port
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    gpc_port_cell #(
      .IMPL_MASK (p == gpc_pkg::IDX_F ? gpc_pkg::MASK_F
                                      : gpc_pkg::MASK_FULL)
    ) u_cell (
      .i_clk      (I_MCLK),
      .i_rst_b    (I_RST_B),
      .i_wr_cfg   (wr_cfg[p]),
      .i_wr_dat   (wr_dat[p]),
      .i_wdata    (I_WDATA),
      .i_pin      (I_PIO_IN[p*8 +: 8]),
      .i_alt_en   (alt_en_w[p]),
      .i_alt_val  (alt_val_w[p]),
      .i_ovr_en   (ovr_en_w[p]),
      .i_ovr_oe   (ovr_oe_w[p]),
      .i_ovr_out  (ovr_out_w[p]),
      .i_ovr_pull (ovr_pull_w[p]),
      .o_cfg      (cfg_w[p]),
      .o_dat      (dat_w[p]),
      .o_level    (level_w[p]),
      .o_out      (out_w[p]),
      .o_oe       (oe_w[p]),
      .o_pull     (pull_w[p])
    );
    assign O_PIO_OUT[p*8 +: 8]    = out_w[p];
    assign O_PIO_OE[p*8 +: 8]     = oe_w[p];
    assign O_PIO_PULLUP[p*8 +: 8] = pull_w[p];
  end

  // Read data, output-only port, power mode requests
  always_comb begin
    s_next = s_reg;
    s_next.halt = 1'b0;
    s_next.idle = 1'b0;
    if (I_RD) begin
      s_next.rdata = '0;
      if (I_ADDR == gpc_pkg::OFF_PORT_D) begin
        s_next.rdata = s_reg.port_d;
      end else if (rd_idx != gpc_pkg::IDX_NONE) begin
        unique case (I_ADDR[1:0])
          gpc_pkg::OFF_CFG: s_next.rdata = cfg_w[rd_idx];
          gpc_pkg::OFF_DAT: begin
            s_next.rdata = dat_w[rd_idx];
            if (rd_idx == 3'(gpc_pkg::IDX_G)) begin
              s_next.rdata = dat_w[rd_idx] & gpc_pkg::G_DAT_RD_MASK;
            end
          end
          gpc_pkg::OFF_PIN: s_next.rdata = level_w[rd_idx];
          default:          s_next.rdata = '0;
        endcase
      end
    end
    if (I_WR && I_ADDR == gpc_pkg::OFF_PORT_D) begin
      s_next.port_d = I_WDATA;
    end
    if (wr_dat[gpc_pkg::IDX_G]) begin
      s_next.halt = I_WDATA[gpc_pkg::G_HALT_BIT];
      s_next.idle = I_WDATA[gpc_pkg::G_IDLE_BIT];
    end
    s_next.dly_en = cfg_w[gpc_pkg::IDX_G][gpc_pkg::G_DELAY_BIT] &
                    I_RC_CLOCK_MODE;
  end

  // State register; port D presets high under reset
  always_ff @(posedge I_MCLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s_reg <= '{port_d: gpc_pkg::RST_PORT_D, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_RDATA                      = s_reg.rdata;
  assign O_PORT_D                     = s_reg.port_d;
  assign O_HALT_REQ                   = s_reg.halt;
  assign O_IDLE_REQ                   = s_reg.idle;
  assign O_HALT_EXIT_STARTUP_DELAY_EN = s_reg.dly_en;
  // Serial clock phase straight from G configuration bit 6
  assign O_SERIAL_ALT_PHASE =
    cfg_w[gpc_pkg::IDX_G][gpc_pkg::G_PHASE_BIT];
  // Synchronised alternate inputs for the peripherals
  assign O_EXTERNAL_INTERRUPT_IN =
    level_w[gpc_pkg::IDX_G][gpc_pkg::G_INT_BIT];
  assign O_TIMER1_CAPTURE_IN =
    level_w[gpc_pkg::IDX_G][gpc_pkg::G_CAP_BIT];
  assign O_TIMER1_IO_IN =
    level_w[gpc_pkg::IDX_G][gpc_pkg::G_T1IO_BIT];
  assign O_SERIAL_DATA_IN =
    level_w[gpc_pkg::IDX_G][gpc_pkg::G_SIN_BIT];
  assign O_SERIAL_SHIFT_CLOCK_IN =
    level_w[gpc_pkg::IDX_G][gpc_pkg::G_SCLK_BIT];
  assign O_WAKEUP_LEVEL = level_w[gpc_pkg::IDX_L];
endmodule
`default_nettype wire

// ===== bench/gpc_monitor.sv
`default_nettype none
module gpc_monitor #(
  parameter int NPORT = 7
) (
  input wire logic               I_MCLK,
  input wire logic               I_RST_B,
  input wire logic [7:0]         I_ADDR,
  input wire logic [7:0]         I_WDATA,
  input wire logic               I_WR,
  input wire logic               I_RD,
  input wire logic [7:0]         O_RDATA,
  input wire logic [NPORT*8-1:0] O_PIO_OUT,
  input wire logic [NPORT*8-1:0] O_PIO_OE,
  input wire logic [NPORT*8-1:0] O_PIO_PULLUP,
  input wire logic               I_WDOG_SEL,
  input wire logic               I_WDOG_OUT_B,
  input wire logic               I_OSC_CLK,
  input wire logic               O_HALT_REQ,
  input wire logic               O_IDLE_REQ,
  input wire logic               O_SERIAL_ALT_PHASE
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);

  // Power requests follow writes to port G output value; serial phase follows its configuration
  halt_req_a: assert property (
    I_WR && I_ADDR == 8'h15 && I_WDATA[7] |=> O_HALT_REQ)
    else $error("halt request missing");
  halt_cause_a: assert property (
    O_HALT_REQ |-> $past(I_WR && I_ADDR == 8'h15 && I_WDATA[7]))
    else $error("halt request without write");
  idle_req_a: assert property (
    I_WR && I_ADDR == 8'h15 && I_WDATA[6] |-> ##1 O_IDLE_REQ)
    else $error("idle request missing");
  phase_sel_a: assert property (
    I_WR && I_ADDR == 8'h14 |=> O_SERIAL_ALT_PHASE == $past(I_WDATA[6]))
    else $error("serial phase not following write");

  // Dedicated and absent pins
  g6_hiz_a: assert property (
    !O_PIO_OE[46] && !O_PIO_PULLUP[46])
    else $error("input-only pin driven or pulled");
  g7_clock_a: assert property (
    $past(I_RST_B) |-> O_PIO_OE[47] && O_PIO_OUT[47] == $past(I_OSC_CLK))
    else $error("clock output pin wrong");
  wdog_pin_a: assert property (
    I_WDOG_SEL && $past(I_WDOG_SEL) && $past(I_RST_B) |->
    O_PIO_OE[41] == !$past(I_WDOG_OUT_B) && O_PIO_PULLUP[41] && !O_PIO_OUT[41])
    else $error("watchdog pin wrong");
  f_upper_a: assert property (
    (O_PIO_OE[39:36] | O_PIO_OUT[39:36] | O_PIO_PULLUP[39:36]) == 4'h0)
    else $error("absent port bits active");

  // Read data of special places
  unmapped_read_a: assert property (
    I_RD && I_ADDR > 8'h1C |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  g_dat_rd_a: assert property (
    I_RD && I_ADDR == 8'h15 |=> O_RDATA[7:6] == 2'h0)
    else $error("power bits read back");
  f_rd_a: assert property (
    I_RD && I_ADDR[7:2] == 6'h04 |=> O_RDATA[7:4] == 4'h0)
    else $error("absent port bits read");
endmodule

bind gpc_top gpc_monitor #(.NPORT(NPORT)) i_gpc_monitor (
  .I_MCLK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
  .O_PIO_OUT, .O_PIO_OE, .O_PIO_PULLUP, .I_WDOG_SEL, .I_WDOG_OUT_B,
  .I_OSC_CLK, .O_HALT_REQ, .O_IDLE_REQ, .O_SERIAL_ALT_PHASE
);
`default_nettype wire

// ===== bench/gpc_top_test.sv
`default_nettype none
module gpc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdat = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [55:0] pin = 56'h0;
  logic        wsel = 1'b0;
  logic        wdog_out_b = 1'b1;
  logic        osc = 1'b0;
  logic        rc = 1'b0;
  logic [7:0]  g_en = 8'h00;
  logic [7:0]  g_val = 8'h00;
  logic [7:0]  l_en = 8'h00;
  logic [7:0]  l_val = 8'h00;
  logic [7:0]  rdata, port_d, wake, c, d;
  logic [55:0] pout, poe, ppu, v;
  logic [4:0]  g_in;
  logic        halt, idle, phase, dly;
  int          mismatches = 0;
  int          check_count = 0;

  gpc_top i_gpc_top (
    .I_MCLK(mclk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdat),
    .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_PIO_IN(pin),
    .O_PIO_OUT(pout), .O_PIO_OE(poe), .O_PIO_PULLUP(ppu), .O_PORT_D(port_d),
    .I_WDOG_SEL(wsel), .I_WDOG_OUT_B(wdog_out_b), .I_OSC_CLK(osc),
    .I_RC_CLOCK_MODE(rc), .I_G_ALT_EN(g_en), .I_G_ALT_OUT(g_val),
    .I_L_ALT_EN(l_en), .I_L_ALT_OUT(l_val), .O_HALT_REQ(halt),
    .O_IDLE_REQ(idle), .O_SERIAL_ALT_PHASE(phase),
    .O_HALT_EXIT_STARTUP_DELAY_EN(dly), .O_EXTERNAL_INTERRUPT_IN(g_in[0]),
    .O_TIMER1_CAPTURE_IN(g_in[1]), .O_TIMER1_IO_IN(g_in[2]),
    .O_SERIAL_SHIFT_CLOCK_IN(g_in[3]), .O_SERIAL_DATA_IN(g_in[4]),
    .O_WAKEUP_LEVEL(wake)
  );

  // Core clock and a toggling oscillator level
  always #2 mclk = ~mclk;
  always @(posedge mclk) osc <= ~osc;

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge mclk);
    addr <= a;
    wdat <= dv;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] mk = 8'hFF);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    chk(rdata & mk, e & mk);
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Implemented bits of output value and pins per port
  function automatic logic [7:0] msk(input int p);
    return p == 4 ? 8'h0F : (p == 5 ? 8'h3F : 8'hFF);
  endfunction

  // Hang guard
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge mclk);
    chk(port_d, 8'hFF);
    rst_b <= 1'b1;
    for (int p = 0; p < 7; p++) begin
      rd(gpc_pkg::PORT_BASE[p], 8'h00);
      rd(gpc_pkg::PORT_BASE[p] + 8'h01, 8'h00);
    end
    rd(8'h1C, 8'hFF);
    $display("reset test done");
    // All four set-ups on alternate bits, both ways round
    for (int k = 0; k < 2; k++) begin
      c = k ? 8'h33 : 8'hCC;
      d = k ? 8'h55 : 8'hAA;
      for (int p = 0; p < 7; p++) begin
        wr(gpc_pkg::PORT_BASE[p], c);
        wr(gpc_pkg::PORT_BASE[p] + 8'h01, d);
        chk(poe[p*8+:8] & msk(p), c & msk(p));
        chk(ppu[p*8+:8] & msk(p), ~c & d & msk(p));
        chk(pout[p*8+:8] & c & msk(p), c & d & msk(p));
        rd(gpc_pkg::PORT_BASE[p], p == 4 ? c & 8'h0F : c);
        rd(gpc_pkg::PORT_BASE[p] + 8'h01, d & msk(p));
      end
    end
    $display("set-up test done");
    // Pin levels whatever the set-up
    for (int k = 0; k < 2; k++) begin
      v = k ? ~56'hA5_3C96_0FF0_5AC3 : 56'hA5_3C96_0FF0_5AC3;
      @(posedge mclk);
      pin <= v;
      tick(4);
      chk(wake, v[55:48]);
      chk(g_in, {v[46], v[45], v[43], v[42], v[40]});
      for (int p = 0; p < 7; p++)
        rd(gpc_pkg::PORT_BASE[p] + 8'h02,
           v[p*8+:8] & (p == 4 ? 8'h0F : 8'hFF),
           p == 5 ? 8'h7F : 8'hFF);
    end
    wr(8'h02, ~v[7:0]);
    rd(8'h02, v[7:0]);
    rd(8'h03, 8'h00);
    rd(8'h1D, 8'h00);
    rd(8'hFF, 8'h00);
    $display("pin test done");
    // Peripheral values on driven pins
    wr(8'h18, 8'hFF);
    wr(8'h14, 8'h3F);
    @(posedge mclk);
    l_en <= 8'hFF;
    l_val <= 8'h5A;
    g_en <= 8'h1F;
    g_val <= 8'h15;
    tick(2);
    chk(pout[55:48], 8'h5A);
    chk(pout[44:40], 5'h15);
    // Power requests, serial phase, restart delay, watchdog pin
    wr(8'h15, 8'hFF);
    chk({halt, idle}, 2'h3);
    tick(1);
    chk({halt, idle}, 2'h0);
    rd(8'h15, 8'h3F);
    wr(8'h14, 8'h40);
    chk(phase, 1'b1);
    wr(8'h14, 8'h80);
    tick(1);
    chk({phase, dly}, 2'h0);
    @(posedge mclk);
    rc <= 1'b1;
    tick(2);
    chk(dly, 1'b1);
    rd(8'h14, 8'h80);
    wr(8'h14, 8'h02);
    wr(8'h15, 8'h02);
    @(posedge mclk);
    wsel <= 1'b1;
    wdog_out_b <= 1'b0;
    tick(2);
    chk({poe[41], pout[41], ppu[41]}, 3'h5);
    @(posedge mclk);
    wdog_out_b <= 1'b1;
    tick(2);
    chk({poe[41], ppu[41]}, 2'h1);
    $display("port G test done");
    // Output-only port, then forced high by a second reset
    wr(8'h1C, 8'h3C);
    chk(port_d, 8'h3C);
    rd(8'h1C, 8'h3C);
    @(posedge mclk);
    rst_b <= 1'b0;
    tick(1);
    chk(port_d, 8'hFF);
    @(posedge mclk);
    rst_b <= 1'b1;
    tick(2);
    chk(port_d, 8'hFF);
    rd(8'h14, 8'h00);
    $display("port D test done");
    give_verdict();
  end
endmodule
`default_nettype wire
